// File: rtl/halt_standby_control.sv
// halt standby controller: cpu clock gating, wake sequencing, peripheral permissions
// assumes cpu core and interrupt controller share mclk; apb slave for control/status
//
// Functional notes
// - halt instruction strobe enters the halt state
// - entry accepted from crystal or ring oscillator cpu clock
// - halted: cpu clock gated, oscillators keep running
// - port output latches keep their pre-halt value
// - ring halt: timer h_a ok only counting running timer50 output
// - ring halt: timer h_b ok only on ring clock divided by 128
// - ring halt: timer50 ok only counting its external pin
// - ring halt: both async channels ok only on running timer50 output
// - ring halt: clocked serial ok only with external clock
// - any unmasked interrupt request ends halt, restoring cpu clock
// - interrupts enabled on release: vectored servicing
// - interrupts disabled on release: next instruction, no vectoring
// - vectored release waits 8 or 9 cpu clocks
// - non-vectored release waits 2 or 3 cpu clocks
// - build option: ring oscillator always on or software stoppable
// - external reset ends halt with normal reset from reset vector
`timescale 1ns/100ps
module halt_standby_control #(
    parameter bit RING_STOPPABLE = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu core side
    input wire logic haltInstr,
    input wire logic cpuOnRing,
    input wire logic [halt_pkg::CPU_DIV_W-1:0] cpuDivRatio,
    input wire logic portWrStb,
    input wire logic [halt_pkg::PORT_W-1:0] portWrData,
    output logic cpuTick,
    output logic cpuResume,
    output logic cpuVector,
    output logic cpuResetVector,
    // interrupt controller side
    input wire logic irqPending,
    input wire logic irqEnable,
    // peripheral side
    input wire halt_pkg::periph_sel_t periphSel,
    output logic [halt_pkg::NUM_PERM-1:0] periphRunOk,
    output logic ringOscRun,
    output logic wdtRun,
    output logic [halt_pkg::PORT_W-1:0] portOut
);
    halt_pkg::halt_state_t state_ff;
    halt_pkg::halt_state_t nxt_state;
    logic srcRing_ff;
    logic vec_ff;
    logic [3:0] wait_ff;
    logic [3:0] nxt_wait;
    logic resume_ff;
    logic vector_ff;
    logic rstVec_ff;
    logic [31:0] ctrl_ff;
    logic [halt_pkg::WAKE_CNT_W-1:0] wakes_ff;
    logic [31:0] rdata_ff;

    // apb decode
    wire apbAccess = psel & penable;
    wire hitCtrl = (paddr == halt_pkg::ADDR_CTRL);
    wire hitStatus = (paddr == halt_pkg::ADDR_STATUS);
    wire hitPeriph = (paddr == halt_pkg::ADDR_PERIPH);
    wire hitAny = hitCtrl | hitStatus | hitPeriph;
    wire wrCtrl = apbAccess & pwrite & hitCtrl;

    // ring oscillator control
    wire ringStopReq = ctrl_ff[halt_pkg::CTRL_RING_STOP_BIT] & RING_STOPPABLE;
    wire ringRunning = ~ringStopReq;

    wire halted = (state_ff == halt_pkg::ST_HALT);
    wire waiting = (state_ff == halt_pkg::ST_WAIT);
    wire wakeReq = halted & irqPending;
    wire waitDone = waiting & cpuTick & (wait_ff == 4'h1);

    // state sequencing
    always_comb
    begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        unique case (state_ff)
            halt_pkg::ST_RUN:
            begin
                if (haltInstr)
                    nxt_state = halt_pkg::ST_HALT;
            end
            halt_pkg::ST_HALT:
            begin
                if (wakeReq)
                begin
                    nxt_state = halt_pkg::ST_WAIT;
                    // vectored path waits longer; fixed at the low figure of each pair
                    nxt_wait = irqEnable ? halt_pkg::WAIT_VEC_MIN : halt_pkg::WAIT_NOVEC_MIN;
                end
            end
            halt_pkg::ST_WAIT:
            begin
                if (cpuTick)
                    nxt_wait = wait_ff - 4'h1;
                if (waitDone)
                    nxt_state = halt_pkg::ST_RUN;
            end
            default:
                nxt_state = halt_pkg::ST_RUN;
        endcase
    end

    // reset returns to run and flags reset-vector start
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= halt_pkg::ST_RUN;
            wait_ff <= 4'h0;
            rstVec_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            rstVec_ff <= 1'b0;
        end
    end

    // capture clock source and wake kind
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            srcRing_ff <= 1'b0;
            vec_ff <= 1'b0;
        end
        else
        begin
            if (state_ff == halt_pkg::ST_RUN && haltInstr)
                srcRing_ff <= cpuOnRing;
            if (wakeReq)
                vec_ff <= irqEnable;
        end
    end

    // one-cycle resume / vector pulses to the core
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resume_ff <= 1'b0;
            vector_ff <= 1'b0;
        end
        else
        begin
            resume_ff <= waitDone;
            vector_ff <= waitDone & vec_ff;
        end
    end

    // wake counter, saturating
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wakes_ff <= '0;
        else if (wakeReq && wakes_ff != '1)
            wakes_ff <= wakes_ff + 1'b1;
    end

    // control register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_ff <= halt_pkg::CTRL_RESET;
        else if (wrCtrl)
            ctrl_ff <= {30'h0, pwdata[1:0]};
    end

    // cpu clock gated only while halted; ticks run again during the release wait
    cpu_clock_divider u_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .divRatio(cpuDivRatio),
        .gateOff(halted),
        .cpuTick(cpuTick)
    );

    // port latches frozen through halt
    port_latch_hold u_port (
        .mclk(mclk),
        .rst_n(rst_n),
        .freeze(halted | (ctrl_ff[halt_pkg::CTRL_PORT_HOLD_BIT] & waiting)),
        .wrStb(portWrStb),
        .wrData(portWrData),
        .portOut(portOut)
    );

    // peripheral run permission: crystal halt lets all run; ring halt restricts
    wire ringHalt = (halted | waiting) & srcRing_ff;
    wire t50Run = periphSel.tmr50Running;
    wire okTmrhA = periphSel.tmrhACountsTmr50 & t50Run;
    wire okTmrhB = periphSel.tmrhBCountsRingDiv128;
    wire okTmr50 = periphSel.tmr50CountsExtPin;
    wire okAsync = periphSel.asyncACountsTmr50 & periphSel.asyncBCountsTmr50 & t50Run;
    wire okCsi = periphSel.csiExtClock;
    wire [halt_pkg::NUM_PERM-1:0] ringPerm;

    assign ringPerm[halt_pkg::PERM_TMR16] = 1'b0;
    assign ringPerm[halt_pkg::PERM_TMR50] = okTmr50;
    assign ringPerm[halt_pkg::PERM_TMRH_A] = okTmrhA;
    assign ringPerm[halt_pkg::PERM_TMRH_B] = okTmrhB;
    assign ringPerm[halt_pkg::PERM_ASYNC] = okAsync;
    assign ringPerm[halt_pkg::PERM_CSI] = okCsi;
    assign ringPerm[halt_pkg::PERM_ADC] = 1'b0;
    assign ringPerm[halt_pkg::PERM_ALWAYS] = 1'b1;

    assign periphRunOk = ringHalt ? ringPerm : {halt_pkg::NUM_PERM{1'b1}};
    assign ringOscRun = ringRunning;
    assign wdtRun = ringRunning;

    // apb read mux
    wire [31:0] statusWord = {16'h0, wakes_ff, 3'h0, ringRunning, ringRunning,
                              vec_ff, srcRing_ff, halted | waiting};
    wire [31:0] rdMux = hitCtrl ? ctrl_ff :
                        hitStatus ? statusWord :
                        hitPeriph ? {24'h0, periphRunOk} : 32'h0;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_ff <= 32'h0;
        else if (psel && !penable && !pwrite)
            rdata_ff <= rdMux;
    end

    assign prdata = rdata_ff;
    assign pready = 1'b1;
    assign pslverr = apbAccess & ~hitAny;
    assign cpuResume = resume_ff;
    assign cpuVector = vector_ff;
    assign cpuResetVector = rstVec_ff;
endmodule : halt_standby_control

// File: inc/halt_pkg.sv
// package for the halt standby controller
// shared constants, register map and carrier structs
package halt_pkg;
    // apb register map (byte addresses)
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_PERIPH = 12'h008;
    // ctrl register fields
    localparam int CTRL_RING_STOP_BIT = 0;
    localparam int CTRL_PORT_HOLD_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // status register fields
    localparam int STAT_HALTED_BIT = 0;
    localparam int STAT_SRC_RING_BIT = 1;
    localparam int STAT_WAKE_VEC_BIT = 2;
    localparam int STAT_WDT_RUN_BIT = 3;
    localparam int STAT_RING_RUN_BIT = 4;
    localparam int STAT_WAKES_LSB = 8;
    // peripheral run-permission bit positions
    localparam int PERM_TMR16 = 0;
    localparam int PERM_TMR50 = 1;
    localparam int PERM_TMRH_A = 2;
    localparam int PERM_TMRH_B = 3;
    localparam int PERM_ASYNC = 4;
    localparam int PERM_CSI = 5;
    localparam int PERM_ADC = 6;
    localparam int PERM_ALWAYS = 7;
    localparam int NUM_PERM = 8;
    // release waits in cpu clocks (first and last allowed figure)
    localparam logic [3:0] WAIT_VEC_MIN = 4'h8;
    localparam logic [3:0] WAIT_VEC_MAX = 4'h9;
    localparam logic [3:0] WAIT_NOVEC_MIN = 4'h2;
    localparam logic [3:0] WAIT_NOVEC_MAX = 4'h3;
    localparam int CPU_DIV_W = 4;
    localparam int WAKE_CNT_W = 8;
    localparam int PORT_W = 8;

    // peripheral clock selections as reported by the peripherals
    typedef struct packed {
        logic tmr50CountsExtPin;
        logic tmr50Running;
        logic tmrhACountsTmr50;
        logic tmrhBCountsRingDiv128;
        logic asyncACountsTmr50;
        logic asyncBCountsTmr50;
        logic csiExtClock;
    } periph_sel_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HALT = 2'b01,
        ST_WAIT = 2'b10
    } halt_state_t;
endpackage : halt_pkg

// File: rtl/cpu_clock_divider.sv
// cpu clock enable divider with halt gating
// assumes mclk is the selected system source; gate driven by the sequencer
`timescale 1ns/100ps
module cpu_clock_divider (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [halt_pkg::CPU_DIV_W-1:0] divRatio,
    input wire logic gateOff,
    output logic cpuTick
);
    logic [halt_pkg::CPU_DIV_W-1:0] cnt_ff;
    logic [halt_pkg::CPU_DIV_W-1:0] nxt_cnt;
    logic tick_ff;
    wire wrap = (cnt_ff >= divRatio);

    assign nxt_cnt = wrap ? '0 : cnt_ff + 1'b1;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            tick_ff <= wrap & ~gateOff;
        end
    end

    assign cpuTick = tick_ff;
endmodule : cpu_clock_divider

// File: rtl/port_latch_hold.sv
// port output latches frozen while halted
// assumes cpu writes arrive as a strobe with data
`timescale 1ns/100ps
module port_latch_hold (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic freeze,
    input wire logic wrStb,
    input wire logic [halt_pkg::PORT_W-1:0] wrData,
    output logic [halt_pkg::PORT_W-1:0] portOut
);
    logic [halt_pkg::PORT_W-1:0] latch_ff;
    wire take = wrStb & ~freeze;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            latch_ff <= '0;
        else if (take)
            latch_ff <= wrData;
    end

    assign portOut = latch_ff;
endmodule : port_latch_hold

// File: test/halt_standby_control_sva.sv
// assertions on the halt standby controller ports
// bound to every instance of the controller
`timescale 1ns/100ps
module halt_standby_control_sva #(
    parameter bit RING_STOPPABLE = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic haltInstr,
    input wire logic cpuOnRing,
    input wire logic irqPending,
    input wire logic irqEnable,
    input wire logic cpuTick,
    input wire logic cpuResume,
    input wire logic cpuVector,
    input wire halt_pkg::periph_sel_t periphSel,
    input wire logic [halt_pkg::NUM_PERM-1:0] periphRunOk,
    input wire logic ringOscRun,
    input wire logic wdtRun,
    input wire logic [halt_pkg::PORT_W-1:0] portOut
);
    logic sleepFf, wakeFf, ringFf, vecFf;
    logic [3:0] tickFf;
    wire ringHalt = sleepFf && ringFf && !wakeFf;
    wire [4:0] expSel = {periphSel.csiExtClock,
        periphSel.asyncACountsTmr50 & periphSel.asyncBCountsTmr50 & periphSel.tmr50Running,
        periphSel.tmrhBCountsRingDiv128, periphSel.tmrhACountsTmr50 & periphSel.tmr50Running,
        periphSel.tmr50CountsExtPin};
    // shadow of halt, wake and ticks seen during the wake wait
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleepFf <= 1'b0;
            wakeFf <= 1'b0;
            ringFf <= 1'b0;
            vecFf <= 1'b0;
            tickFf <= 4'h0;
        end
        else
        begin
            if (haltInstr && !sleepFf)
            begin
                sleepFf <= 1'b1;
                ringFf <= cpuOnRing;
            end
            if (sleepFf && !wakeFf && irqPending)
            begin
                wakeFf <= 1'b1;
                vecFf <= irqEnable;
                tickFf <= 4'h0;
            end
            else if (wakeFf && cpuTick)
                tickFf <= tickFf + 4'h1;
            if (cpuResume)
            begin
                sleepFf <= 1'b0;
                wakeFf <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_haltGate;
        sleepFf && !wakeFf && $past(sleepFf) |-> !cpuTick;
    endproperty
    a_haltGate: assert property (p_haltGate) else $error("cpu tick while halted");
    property p_oscKept;
        $rose(sleepFf) |-> ringOscRun == $past(ringOscRun);
    endproperty
    a_oscKept: assert property (p_oscKept) else $error("oscillator changed at halt");
    property p_portHold;
        sleepFf && !wakeFf && $past(sleepFf) |-> $stable(portOut);
    endproperty
    a_portHold: assert property (p_portHold) else $error("port latch moved while halted");
    property p_wakeBound;
        $rose(wakeFf) |-> ##[1:300] cpuResume;
    endproperty
    a_wakeBound: assert property (p_wakeBound) else $error("no release after request");
    property p_vecChoice;
        cpuResume |-> cpuVector == vecFf;
    endproperty
    a_vecChoice: assert property (p_vecChoice) else $error("wrong vectoring choice");
    property p_vecWait;
        cpuResume && cpuVector |-> tickFf inside {4'h8, 4'h9};
    endproperty
    a_vecWait: assert property (p_vecWait) else $error("vectored wait length");
    property p_plainWait;
        cpuResume && !cpuVector |-> tickFf inside {4'h2, 4'h3};
    endproperty
    a_plainWait: assert property (p_plainWait) else $error("plain wait length");
    property p_ringPerm;
        ringHalt |-> periphRunOk == {1'b1, 1'b0, expSel, 1'b0};
    endproperty
    a_ringPerm: assert property (p_ringPerm) else $error("ring halt permissions");
    property p_fullPerm;
        !sleepFf || !ringFf |-> periphRunOk == 8'hff;
    endproperty
    a_fullPerm: assert property (p_fullPerm) else $error("permissions not all set");
    property p_wdt;
        wdtRun == ringOscRun;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog not following ring");
    c_vec: cover property (cpuResume && cpuVector);
    c_plain: cover property (cpuResume && !cpuVector);
    c_ring: cover property (ringHalt);
endmodule : halt_standby_control_sva

bind halt_standby_control halt_standby_control_sva #(.RING_STOPPABLE(RING_STOPPABLE)) u_halt_standby_control_sva (
    .mclk, .rst_n, .haltInstr, .cpuOnRing, .irqPending, .irqEnable, .cpuTick, .cpuResume,
    .cpuVector, .periphSel, .periphRunOk, .ringOscRun, .wdtRun, .portOut);

// File: test/cpu_irq_model.sv
// cpu core and interrupt controller model
// commands come from the bench; instructions run on cpu ticks
`timescale 1ns/100ps
module cpu_irq_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic goHalt,
    input wire logic raiseIrq,
    input wire logic rogueWr,
    input wire logic cpuTick,
    input wire logic cpuResume,
    output logic haltInstr,
    output logic irqPending,
    output logic portWrStb,
    output logic [halt_pkg::PORT_W-1:0] portWrData
);
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            haltInstr <= 1'b0;
            irqPending <= 1'b0;
            portWrStb <= 1'b0;
            portWrData <= 8'h00;
        end
        else
        begin
            haltInstr <= goHalt && cpuTick;
            // request held until the release is answered
            if (raiseIrq)
                irqPending <= 1'b1;
            else if (cpuResume)
                irqPending <= 1'b0;
            // a port write per instruction, or forced on command
            portWrStb <= cpuTick || rogueWr;
            portWrData <= portWrData + 8'h01;
        end
    end
endmodule : cpu_irq_model

// File: test/halt_standby_control_tb.sv
// self-checking bench for the halt standby controller
// apb master and model commands here; checker is bound in
`timescale 1ns/100ps
module halt_standby_control_tb;
    logic mclk, rst_n, psel, penable, pwrite, cpuOnRing, irqEnable, goHalt, raiseIrq, rogueWr, err;
    logic pready, pslverr, haltInstr, portWrStb, cpuTick, cpuResume, cpuVector, cpuResetVector;
    logic irqPending, ringOscRun, wdtRun;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] cpuDivRatio;
    logic [7:0] portWrData, periphRunOk, portOut, held;
    halt_pkg::periph_sel_t periphSel;
    int nFail, comparisons, seed, t0;
    int ticks = 0;
    halt_standby_control #(.RING_STOPPABLE(1'b1)) u_halt_standby_control (.mclk, .rst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .haltInstr, .cpuOnRing,
        .cpuDivRatio, .portWrStb, .portWrData, .cpuTick, .cpuResume, .cpuVector, .cpuResetVector,
        .irqPending, .irqEnable, .periphSel, .periphRunOk, .ringOscRun, .wdtRun, .portOut);
    cpu_irq_model u_cpu_irq_model (.mclk, .rst_n, .goHalt, .raiseIrq, .rogueWr, .cpuTick,
        .cpuResume, .haltInstr, .irqPending, .portWrStb, .portWrData);
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (cpuTick)
            ticks <= ticks + 1;
    task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
        comparisons++;
        if (got !== expv)
        begin
            nFail++;
            $display("unexpected %s: expected %h, seen %h", what, expv, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        for (int n = 0; n < 16 && pready !== 1'b1; n++)
            @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic doHalt(input logic ring);
        @(posedge mclk);
        cpuOnRing <= ring;
        goHalt <= 1'b1;
        for (int n = 0; n < 60 && haltInstr !== 1'b1; n++)
            @(posedge mclk);
        goHalt <= 1'b0;
    endtask : doHalt
    function automatic logic [7:0] expPerm(input logic ring, input halt_pkg::periph_sel_t s);
        if (!ring)
            return 8'hff;
        return {2'b10, s.csiExtClock, s.asyncACountsTmr50 & s.asyncBCountsTmr50 & s.tmr50Running,
            s.tmrhBCountsRingDiv128, s.tmrhACountsTmr50 & s.tmr50Running, s.tmr50CountsExtPin, 1'b0};
    endfunction : expPerm
    task automatic giveVerdict();
        $display("comparisons %0d, mismatches %0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : giveVerdict
    initial
    begin
        #500000;
        nFail++;
        giveVerdict();
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, cpuOnRing, irqEnable, goHalt, raiseIrq, rogueWr} = '0;
        {paddr, pwdata, nFail, comparisons} = '0;
        cpuDivRatio = 4'h3;
        periphSel = '0;
        seed = 6;
        repeat (8) @(posedge mclk);
        check("reset vector", 1, 32'(cpuResetVector));
        rst_n <= 1'b1;
        apb(1'b0, halt_pkg::ADDR_CTRL, 32'h0);
        check("ctrl", halt_pkg::CTRL_RESET, rd);
        apb(1'b0, 12'h0f0, 32'h0);
        check("slverr", 1, 32'(err));
        $display("test registers done");
        for (int i = 0; i < 8; i++)
        begin
            cpuDivRatio <= 4'($random(seed)) | 4'h1;
            periphSel <= 7'($random(seed));
            irqEnable <= i[1];
            doHalt(i[0]);
            repeat (3) @(posedge mclk);
            held = portOut;
            t0 = ticks;
            rogueWr <= 1'b1;
            repeat (20) @(posedge mclk);
            rogueWr <= 1'b0;
            check("port latch", 32'(held), 32'(portOut));
            check("halt ticks", 0, 32'(ticks - t0));
            check("ring osc", 1, 32'(ringOscRun));
            check("perms", 32'(expPerm(i[0], periphSel)), 32'(periphRunOk));
            apb(1'b0, halt_pkg::ADDR_PERIPH, 32'h0);
            check("perm reg", 32'(expPerm(i[0], periphSel)), rd);
            apb(1'b0, halt_pkg::ADDR_STATUS, 32'h0);
            check("status src", {30'h0, i[0], 1'b1}, {30'h0, rd[1:0]});
            raiseIrq <= 1'b1;
            @(posedge mclk);
            raiseIrq <= 1'b0;
            t0 = ticks;
            for (int n = 0; n < 400 && cpuResume !== 1'b1; n++)
                @(posedge mclk);
            check("vector", 32'(i[1]), 32'(cpuVector));
            check("wait ok", 1, 32'((ticks - t0) inside {8, 9} == i[1] && ticks - t0 > 1));
            repeat (40) @(posedge mclk);
            check("port writes resume", 1, 32'(portOut !== held));
        end
        $display("test halt and wake done");
        doHalt(1'b1);
        repeat (4) @(posedge mclk);
        rst_n <= 1'b0;
        @(posedge mclk);
        check("reset vector", 1, 32'(cpuResetVector));
        rst_n <= 1'b1;
        t0 = ticks;
        repeat (40) @(posedge mclk);
        check("run after reset", 1, 32'(ticks > t0));
        $display("test reset in halt done");
        apb(1'b1, halt_pkg::ADDR_CTRL, 32'h1);
        @(negedge mclk);
        check("ring stopped", 0, 32'(ringOscRun));
        check("wdt stopped", 0, 32'(wdtRun));
        apb(1'b1, halt_pkg::ADDR_CTRL, 32'h0);
        @(negedge mclk);
        check("wdt running", 1, 32'(wdtRun));
        $display("test ring stop done");
        giveVerdict();
    end
endmodule : halt_standby_control_tb
